//--- hdl/venc_backend.sv
/*
  Encoder output back end: chroma modulation, composite build and limiting,
  closed caption insertion, RGB matrix, output routing and power down.
  Assumes all inputs synchronous to CLK_IN and line/field counts from the
  timing generator; host control bits arrive as plain levels.
*/
`default_nettype none
// Functional notes
// - NCO plus sine table modulates chroma
// - scale sine table, not CbCr path
// - phase zero after reset, then drifts
// - optional NCO clear every 4/8 fields
// - composite sums luma, chroma, sync, burst, pedestal
// - optional clamp active video above eighth-scale
// - caption line: run-in, start, data; inputs ignored on composite and luma
// - two 16-bit caption words, standard-specific lines
// - caption words shift out LSB first
// - unreloaded word is resent
// - status clears on load, sets after send
// - enable code selects lines; disabled reads one
// - band-limited transitions on edges and caption
// - new 10-bit sample each DAC every cycle
// - S-video: luma, chroma, two composites aligned
// - RGB matrix per standard, aligned with composite
// - sync on green optional, no caption RGB
// - SCART clear routing
// - SCART set routing
// - per-DAC enable
// - power-down zeroes DACs, reference, stops pipeline
// - output format field coding
// - video standard field coding
module venc_backend
  import venc_pkg::*;
(
  // clock and reset
  input  wire logic              CLK_IN,
  input  wire logic              RST_N_IN,
  // control bits
  input  wire logic [7:0]        OUT_FORMAT_IN,
  input  wire logic              SCART_IN,
  input  wire logic              LIMIT_EN_IN,
  input  wire logic              PEDESTAL_EN_IN,
  input  wire logic              PHASE_RESET_EN_IN,
  input  wire logic [1:0]        CC_ENABLE_IN,
  input  wire logic [3:0]        DAC_EN_IN,
  input  wire logic              POWER_DOWN_IN,
  input  wire logic [31:0]       SC_INCR_IN,
  // caption byte writes
  input  wire logic              CC_EARLY_LO_WR_IN,
  input  wire logic              CC_EARLY_HI_WR_IN,
  input  wire logic              CC_LATE_LO_WR_IN,
  input  wire logic              CC_LATE_HI_WR_IN,
  input  wire logic [7:0]        CC_DATA_IN,
  // timing
  input  wire logic [9:0]        LINE_IN,
  input  wire logic [9:0]        PIXEL_IN,
  input  wire logic              FIELD_START_IN,
  input  wire logic              ACTIVE_IN,
  input  wire logic              SYNC_IN,
  input  wire logic              BURST_IN,
  // filtered video
  input  wire logic [7:0]        Y_IN,
  input  wire logic signed [7:0] CB_IN,
  input  wire logic signed [7:0] CR_IN,
  // status
  output logic                   CC_EARLY_STATUS_OUT,
  output logic                   CC_LATE_STATUS_OUT,
  // converters
  output logic [9:0]             OUTPUT_ONE_OUT,
  output logic [9:0]             OUTPUT_TWO_OUT,
  output logic [9:0]             OUTPUT_THREE_OUT,
  output logic [9:0]             OUTPUT_FOUR_OUT,
  output logic                   VREF_EN_OUT
);
  logic [1:0]        fmt;
  logic [2:0]        std;
  logic              is_pal;
  logic              is_mpal;
  logic              rgb_mode;
  logic              run;
  logic [2:0]        field_cnt;
  logic              nco_clear;
  logic signed [8:0] sc_sin;
  logic signed [8:0] sc_cos;
  logic [15:0]       cc_early;
  logic [15:0]       cc_late;
  logic [1:0]        early_wr;
  logic [1:0]        late_wr;
  logic              early_sent;
  logic              late_sent;
  cc_state_t         cc_state;
  logic [4:0]        cc_bit;
  logic [3:0]        cc_cyc;
  logic [15:0]       cc_shift;
  logic              cc_line_early;
  logic              cc_line_late;
  logic              cc_active;
  logic [7:0]        cc_level;
  logic [7:0]        cc_smooth;
  logic [9:0]        edge_env;
  logic [9:0]        comp;
  logic [9:0]        luma;
  logic [9:0]        chroma;
  logic [9:0]        red;
  logic [9:0]        green;
  logic [9:0]        blue;

  assign fmt      = OUT_FORMAT_IN[FMT_MSB:FMT_LSB];
  assign std      = OUT_FORMAT_IN[STD_MSB:STD_LSB];
  assign is_pal   = (std == STD_PAL_BDG) || (std == STD_PAL_M) ||
                    (std == STD_PAL_N) || (std == STD_PAL_CN);
  assign is_mpal  = (std == STD_PAL_M);
  assign rgb_mode = (fmt == FMT_RGB) || (fmt == FMT_RGB_SOG);
  assign run      = !POWER_DOWN_IN;

  // saturate a signed sum into the converter range
  function automatic logic [9:0] sat10(input logic signed [12:0] v);
    if (v < 13'sh0000) sat10 = 10'h000;
    else if (v > $signed({3'h0, DAC_MAX})) sat10 = DAC_MAX;
    else sat10 = v[9:0];
  endfunction

  // ----------------------------------------
  // subcarrier and phase reset
  // ----------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      field_cnt <= 3'h0;
      nco_clear <= 1'b0;
    end else begin
      nco_clear <= 1'b0;
      if (run && FIELD_START_IN) begin
        if ((is_pal && field_cnt == PAL_FIELDS) ||
            (!is_pal && field_cnt[1:0] == NTSC_FIELDS)) begin
          field_cnt <= 3'h0;
          nco_clear <= PHASE_RESET_EN_IN;
        end else begin
          field_cnt <= field_cnt + 3'h1;
        end
      end
    end
  end

  venc_nco u_nco (
    .clk_in   (CLK_IN),
    .rst_n_in (RST_N_IN),
    .run_in   (run),
    .clear_in (nco_clear),
    .incr_in  (SC_INCR_IN),
    .amp_in   (is_pal ? SC_AMP_PAL : SC_AMP_NTSC),
    .sin_out  (sc_sin),
    .cos_out  (sc_cos)
  );

  // ----------------------------------------
  // caption words and write status
  // ----------------------------------------
  assign cc_line_early = CC_ENABLE_IN[0] && (LINE_IN == (is_mpal ? CC_EARLY_MPAL :
                         is_pal ? CC_EARLY_PAL : CC_EARLY_NTSC));
  assign cc_line_late  = CC_ENABLE_IN[1] && (LINE_IN == (is_mpal ? CC_LATE_MPAL :
                         is_pal ? CC_LATE_PAL : CC_LATE_NTSC));

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      cc_early <= 16'h8080;
      cc_late  <= 16'h8080;
      early_wr <= 2'h0;
      late_wr  <= 2'h0;
    end else begin
      if (CC_EARLY_LO_WR_IN) cc_early[7:0]  <= CC_DATA_IN;
      if (CC_EARLY_HI_WR_IN) cc_early[15:8] <= CC_DATA_IN;
      if (CC_LATE_LO_WR_IN)  cc_late[7:0]   <= CC_DATA_IN;
      if (CC_LATE_HI_WR_IN)  cc_late[15:8]  <= CC_DATA_IN;
      // byte-pair tracking; a completed pair or a send clears it
      early_wr <= ((early_sent || early_wr == 2'h3) ? 2'h0 : early_wr) |
                  {CC_EARLY_HI_WR_IN, CC_EARLY_LO_WR_IN};
      late_wr  <= ((late_sent || late_wr == 2'h3) ? 2'h0 : late_wr) |
                  {CC_LATE_HI_WR_IN, CC_LATE_LO_WR_IN};
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      CC_EARLY_STATUS_OUT <= 1'b1;
      CC_LATE_STATUS_OUT  <= 1'b1;
    end else begin
      // loaded wins over sent when both land together
      CC_EARLY_STATUS_OUT <= !CC_ENABLE_IN[0] ? 1'b1 :
                             (early_wr == 2'h3) ? 1'b0 :
                             early_sent ? 1'b1 : CC_EARLY_STATUS_OUT;
      CC_LATE_STATUS_OUT  <= !CC_ENABLE_IN[1] ? 1'b1 :
                             (late_wr == 2'h3) ? 1'b0 :
                             late_sent ? 1'b1 : CC_LATE_STATUS_OUT;
    end
  end

  // ----------------------------------------
  // caption serializer
  // ----------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      cc_state   <= CC_IDLE;
      cc_bit     <= 5'h00;
      cc_cyc     <= 4'h0;
      cc_shift   <= 16'h0000;
      cc_active  <= 1'b0;
      early_sent <= 1'b0;
      late_sent  <= 1'b0;
    end else begin
      early_sent <= 1'b0;
      late_sent  <= 1'b0;
      if (run) begin
        case (cc_state)
          CC_IDLE: begin
            cc_active <= cc_active && (cc_line_early || cc_line_late);
            if ((cc_line_early || cc_line_late) && PIXEL_IN == 10'h000) begin
              cc_active <= 1'b1;
              cc_shift  <= cc_line_early ? cc_early : cc_late;
              cc_bit    <= 5'h00;
              cc_cyc    <= 4'h0;
              cc_state  <= CC_RUNIN;
            end
          end
          CC_RUNIN, CC_DATA: begin
            if (PIXEL_IN >= CC_START_PIX) begin
              if (cc_cyc == CC_BIT_CYC - 4'h1) begin
                cc_cyc <= 4'h0;
                cc_bit <= cc_bit + 5'h01;
                if (cc_state == CC_DATA) cc_shift <= {1'b0, cc_shift[15:1]};
                if (cc_bit == CC_RUNIN_BITS + 5'h02) cc_state <= CC_DATA;
                if (cc_bit == CC_TOTAL_BITS - 5'h01) begin
                  cc_state   <= CC_IDLE;
                  early_sent <= LINE_IN != CC_LATE_NTSC && cc_line_early;
                  late_sent  <= cc_line_late;
                end
              end else begin
                cc_cyc <= cc_cyc + 4'h1;
              end
            end
            if (PIXEL_IN == 10'h000 && cc_bit != 5'h00) cc_state <= CC_IDLE;
          end
          default: cc_state <= CC_IDLE;
        endcase
      end
    end
  end

  // run-in toggles, start bits 0,0,1, then data LSB first
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      cc_level <= CC_LOW;
    end else if (run) begin
      if (cc_state == CC_RUNIN && PIXEL_IN >= CC_START_PIX) begin
        cc_level <= (cc_bit < CC_RUNIN_BITS) ? (cc_bit[0] ? CC_LOW : CC_HIGH) :
                    (cc_bit == CC_RUNIN_BITS + 5'h02) ? CC_HIGH : CC_LOW;
      end else if (cc_state == CC_DATA) begin
        cc_level <= cc_shift[0] ? CC_HIGH : CC_LOW;
      end else begin
        cc_level <= CC_LOW;
      end
    end
  end

  // ----------------------------------------
  // edge shaping: slew the caption level and blanking envelope
  // ----------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      cc_smooth <= CC_LOW;
      edge_env  <= 10'h000;
    end else if (run) begin
      cc_smooth <= 8'((9'(cc_smooth) + 9'(cc_level)) >> 1);
      edge_env  <= 10'((11'(edge_env) +
                   ((ACTIVE_IN || BURST_IN) ? 11'h100 : 11'h000)) >> 1);
    end
  end

  // ----------------------------------------
  // composite, S-video and RGB pipeline
  // ----------------------------------------
  always_ff @(posedge CLK_IN) begin : pipe
    logic signed [16:0] mod;
    logic signed [12:0] y_s;
    logic signed [12:0] sum;
    logic signed [12:0] cb_s;
    logic signed [12:0] cr_s;
    logic signed [12:0] sync_lvl;
    mod      = 17'sh00000;
    y_s      = 13'sh0000;
    sum      = 13'sh0000;
    cb_s     = 13'sh0000;
    cr_s     = 13'sh0000;
    sync_lvl = 13'sh0000;
    if (!RST_N_IN) begin
      comp   <= PIPE_RESET;
      luma   <= PIPE_RESET;
      chroma <= PIPE_RESET;
      red    <= PIPE_RESET;
      green  <= PIPE_RESET;
      blue   <= PIPE_RESET;
    end else if (run) begin
      mod  = (CB_IN * sc_sin + CR_IN * sc_cos) >>> 7;
      if (BURST_IN) mod = -(17'(sc_sin) * 17'sh00004) >>> 4;
      mod  = (mod * $signed({7'h00, edge_env})) >>> 8;
      y_s  = cc_active ? $signed({5'h00, cc_smooth}) : $signed({5'h00, Y_IN});
      if (!ACTIVE_IN && !cc_active) y_s = 13'sh0000;
      sync_lvl = SYNC_IN ? 13'sh0000 : 13'sh00f0;
      sum  = sync_lvl + (y_s <<< 1) + (cc_active ? 13'sh0000 : mod[12:0]) +
             ((PEDESTAL_EN_IN && std != STD_NTSC_NS && ACTIVE_IN) ?
             13'sh0020 : 13'sh0000);
      if (LIMIT_EN_IN && ACTIVE_IN && !cc_active &&
          sum < $signed({3'h0, LIMIT_MIN})) begin
        sum = $signed({3'h0, LIMIT_MIN});
      end
      comp   <= sat10(sum);
      luma   <= sat10(sync_lvl + (y_s <<< 1));
      chroma <= sat10(13'sh0200 + mod[12:0]);
      cb_s   = ACTIVE_IN ? 13'(CB_IN) : 13'sh0000;
      cr_s   = ACTIVE_IN ? 13'(CR_IN) : 13'sh0000;
      y_s    = ACTIVE_IN ? $signed({5'h00, Y_IN}) : 13'sh0000;
      // coefficient sets differ by level standard; captions excluded
      red    <= sat10(13'sh00f0 + (y_s <<< 1) +
                (is_pal ? (cr_s * 13'sh0005) >>> 1 : (cr_s * 13'sh000b) >>> 2));
      blue   <= sat10(13'sh00f0 + (y_s <<< 1) +
                (is_pal ? (cb_s * 13'sh0007) >>> 1 : (cb_s * 13'sh000e) >>> 2));
      green  <= sat10(((fmt == FMT_RGB_SOG) ? sync_lvl : 13'sh00f0) + (y_s <<< 1) -
                (is_pal ? (cb_s + (cr_s <<< 1)) >>> 1 : (cb_s + cr_s * 13'sh0003) >>> 1));
    end
  end

  // ----------------------------------------
  // routing, enables and power down
  // ----------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      OUTPUT_ONE_OUT   <= PIPE_RESET;
      OUTPUT_TWO_OUT   <= PIPE_RESET;
      OUTPUT_THREE_OUT <= PIPE_RESET;
      OUTPUT_FOUR_OUT  <= PIPE_RESET;
      VREF_EN_OUT      <= 1'b0;
    end else if (POWER_DOWN_IN) begin
      OUTPUT_ONE_OUT   <= 10'h000;
      OUTPUT_TWO_OUT   <= 10'h000;
      OUTPUT_THREE_OUT <= 10'h000;
      OUTPUT_FOUR_OUT  <= 10'h000;
      VREF_EN_OUT      <= 1'b0;
    end else begin
      VREF_EN_OUT <= 1'b1;
      if (!rgb_mode) begin
        OUTPUT_ONE_OUT   <= DAC_EN_IN[0] ? luma : 10'h000;
        OUTPUT_TWO_OUT   <= DAC_EN_IN[1] ? chroma : 10'h000;
        OUTPUT_THREE_OUT <= DAC_EN_IN[2] ? comp : 10'h000;
        OUTPUT_FOUR_OUT  <= DAC_EN_IN[3] ? comp : 10'h000;
      end else if (!SCART_IN) begin
        OUTPUT_ONE_OUT   <= DAC_EN_IN[0] ? green : 10'h000;
        OUTPUT_TWO_OUT   <= DAC_EN_IN[1] ? blue : 10'h000;
        OUTPUT_THREE_OUT <= DAC_EN_IN[2] ? comp : 10'h000;
        OUTPUT_FOUR_OUT  <= DAC_EN_IN[3] ? red : 10'h000;
      end else begin
        OUTPUT_ONE_OUT   <= DAC_EN_IN[0] ? comp : 10'h000;
        OUTPUT_TWO_OUT   <= DAC_EN_IN[1] ? red : 10'h000;
        OUTPUT_THREE_OUT <= DAC_EN_IN[2] ? green : 10'h000;
        OUTPUT_FOUR_OUT  <= DAC_EN_IN[3] ? blue : 10'h000;
      end
    end
  end
endmodule
`default_nettype wire

//--- shared/venc_pkg.sv
/*
  Constants shared by the encoder output back end: control field layouts,
  standards, output formats, caption line numbers and timing counts.
  Assumes a 10 MHz double-rate clock and line/field counters from timing logic.
*/
`default_nettype none
package venc_pkg;
  // ----------------------------------------
  // control field layout (output format byte)
  // ----------------------------------------
  localparam int FMT_LSB        = 3;
  localparam int FMT_MSB        = 4;
  localparam int STD_LSB        = 5;
  localparam int STD_MSB        = 7;
  // ----------------------------------------
  // codes
  // ----------------------------------------
  localparam logic [1:0] FMT_SVIDEO  = 2'h0;
  localparam logic [1:0] FMT_RESV    = 2'h1;
  localparam logic [1:0] FMT_RGB     = 2'h2;
  localparam logic [1:0] FMT_RGB_SOG = 2'h3;
  localparam logic [2:0] STD_NTSC_M  = 3'h0;
  localparam logic [2:0] STD_NTSC_NS = 3'h1;
  localparam logic [2:0] STD_PAL_BDG = 3'h2;
  localparam logic [2:0] STD_PAL_M   = 3'h3;
  localparam logic [2:0] STD_PAL_N   = 3'h4;
  localparam logic [2:0] STD_PAL_CN  = 3'h5;
  // ----------------------------------------
  // caption lines
  // ----------------------------------------
  localparam logic [9:0] CC_EARLY_NTSC = 10'h015;
  localparam logic [9:0] CC_EARLY_MPAL = 10'h012;
  localparam logic [9:0] CC_EARLY_PAL  = 10'h016;
  localparam logic [9:0] CC_LATE_NTSC  = 10'h11c;
  localparam logic [9:0] CC_LATE_MPAL  = 10'h119;
  localparam logic [9:0] CC_LATE_PAL   = 10'h14f;
  // ----------------------------------------
  // caption timing (cycles of the double-rate clock)
  // ----------------------------------------
  localparam logic [9:0] CC_START_PIX  = 10'h014;
  localparam logic [4:0] CC_RUNIN_BITS = 5'h09;
  localparam logic [4:0] CC_TOTAL_BITS = 5'h1c;
  localparam logic [3:0] CC_BIT_CYC    = 4'h5;
  localparam logic [7:0] CC_HIGH       = 8'hb0;
  localparam logic [7:0] CC_LOW        = 8'h10;
  // ----------------------------------------
  // levels and sizes
  // ----------------------------------------
  localparam logic [9:0] LIMIT_MIN     = 10'h080;
  localparam logic [9:0] DAC_MAX       = 10'h3ff;
  localparam logic [1:0] NTSC_FIELDS   = 2'h3;
  localparam logic [2:0] PAL_FIELDS    = 3'h7;
  localparam logic [7:0] SC_AMP_NTSC   = 8'h5a;
  localparam logic [7:0] SC_AMP_PAL    = 8'h56;
  localparam logic [9:0] PIPE_RESET    = 10'h000;
  typedef enum logic [1:0] {CC_IDLE, CC_RUNIN, CC_DATA} cc_state_t;
endpackage
`default_nettype wire

//--- hdl/venc_nco.sv
/*
  Subcarrier oscillator: phase accumulator, sine table and amplitude scaling.
  Assumes a phase increment held steady by the controller.
*/
`default_nettype none
module venc_nco
  import venc_pkg::*;
(
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // control
  input  wire logic              run_in,
  input  wire logic              clear_in,
  input  wire logic [31:0]       incr_in,
  input  wire logic [7:0]        amp_in,
  // subcarrier
  output logic signed [8:0]      sin_out,
  output logic signed [8:0]      cos_out
);
  logic [31:0] phase;

  // ----------------------------------------
  // quarter-wave sine, 16 steps
  // ----------------------------------------
  function automatic logic [7:0] quarter(input logic [3:0] i);
    case (i)
      4'h0: quarter = 8'h00;  4'h1: quarter = 8'h19;
      4'h2: quarter = 8'h31;  4'h3: quarter = 8'h4a;
      4'h4: quarter = 8'h61;  4'h5: quarter = 8'h78;
      4'h6: quarter = 8'h8e;  4'h7: quarter = 8'ha2;
      4'h8: quarter = 8'hb5;  4'h9: quarter = 8'hc5;
      4'ha: quarter = 8'hd4;  4'hb: quarter = 8'he1;
      4'hc: quarter = 8'hec;  4'hd: quarter = 8'hf4;
      4'he: quarter = 8'hfb;  default: quarter = 8'hfe;
    endcase
  endfunction

  // scaled full-wave sine of a 6-bit phase
  function automatic logic signed [8:0] wave(input logic [5:0] p, input logic [7:0] a);
    logic [3:0]  idx;
    logic [15:0] prod;
    idx  = p[4] ? ~p[3:0] : p[3:0];
    prod = quarter(idx) * a;
    wave = p[5] ? -$signed({1'b0, prod[15:8]}) : $signed({1'b0, prod[15:8]});
  endfunction

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      phase <= 32'h0000_0000;
    end else if (clear_in) begin
      phase <= 32'h0000_0000;
    end else if (run_in) begin
      phase <= phase + incr_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sin_out <= 9'sh000;
      cos_out <= 9'sh000;
    end else if (run_in) begin
      sin_out <= wave(phase[31:26], amp_in);
      cos_out <= wave(phase[31:26] + 6'h10, amp_in);
    end
  end
endmodule
`default_nettype wire

//--- dv/venc_backend_assertions.sv
/*
  Concurrent checks on the encoder back end ports.
  Assumes bind onto venc_backend; single clock, sync active-low reset.
*/
`default_nettype none
module venc_backend_checker
  import venc_pkg::*;
(
  input wire logic       CLK_IN,
  input wire logic       RST_N_IN,
  input wire logic [7:0] OUT_FORMAT_IN,
  input wire logic [1:0] CC_ENABLE_IN,
  input wire logic [3:0] DAC_EN_IN,
  input wire logic       POWER_DOWN_IN,
  input wire logic       CC_EARLY_LO_WR_IN,
  input wire logic       CC_EARLY_HI_WR_IN,
  input wire logic       CC_EARLY_STATUS_OUT,
  input wire logic       CC_LATE_STATUS_OUT,
  input wire logic [9:0] OUTPUT_ONE_OUT,
  input wire logic [9:0] OUTPUT_TWO_OUT,
  input wire logic [9:0] OUTPUT_THREE_OUT,
  input wire logic [9:0] OUTPUT_FOUR_OUT,
  input wire logic       VREF_EN_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // ----
  // assertions
  // ----
  sequence pd_held;
    POWER_DOWN_IN [*3];
  endsequence
  a_pd_zero_dacs: assert property (pd_held |-> {OUTPUT_ONE_OUT, OUTPUT_TWO_OUT,
    OUTPUT_THREE_OUT, OUTPUT_FOUR_OUT} == 40'h0) else $error("dac live in power down");
  a_pd_vref_off: assert property (pd_held |-> !VREF_EN_OUT)
    else $error("reference on in power down");
  a_dac_one_off: assert property (!DAC_EN_IN[0] [*3] |-> OUTPUT_ONE_OUT == 10'h000)
    else $error("output one live while off");
  a_dac_two_off: assert property (!DAC_EN_IN[1] [*3] |-> OUTPUT_TWO_OUT == 10'h000)
    else $error("output two live while off");
  a_dac_three_off: assert property (!DAC_EN_IN[2] [*3] |-> OUTPUT_THREE_OUT == 10'h000)
    else $error("output three live while off");
  a_dac_four_off: assert property (!DAC_EN_IN[3] [*3] |-> OUTPUT_FOUR_OUT == 10'h000)
    else $error("output four live while off");
  a_svideo_comp_twin: assert property ((!OUT_FORMAT_IN[4] && DAC_EN_IN[3] && DAC_EN_IN[2]
    && !POWER_DOWN_IN) [*4] |-> OUTPUT_THREE_OUT == OUTPUT_FOUR_OUT)
    else $error("composite copies differ");
  a_early_dis_status: assert property (!CC_ENABLE_IN[0] [*2] |-> CC_EARLY_STATUS_OUT)
    else $error("early status low while disabled");
  a_late_dis_status: assert property (!CC_ENABLE_IN[1] [*2] |-> CC_LATE_STATUS_OUT)
    else $error("late status low while disabled");
  a_early_load_clear: assert property ($fell(CC_EARLY_STATUS_OUT) |->
    $past(CC_EARLY_LO_WR_IN || CC_EARLY_HI_WR_IN, 2) && $past(CC_ENABLE_IN[0]))
    else $error("early status cleared without load");
  c_cc_loaded: cover property ($fell(CC_EARLY_STATUS_OUT));
  c_cc_sent: cover property ($rose(CC_EARLY_STATUS_OUT));
  c_pd_seen: cover property (pd_held);
endmodule
bind venc_backend venc_backend_checker chk_u (
  .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .OUT_FORMAT_IN(OUT_FORMAT_IN),
  .CC_ENABLE_IN(CC_ENABLE_IN), .DAC_EN_IN(DAC_EN_IN), .POWER_DOWN_IN(POWER_DOWN_IN),
  .CC_EARLY_LO_WR_IN(CC_EARLY_LO_WR_IN), .CC_EARLY_HI_WR_IN(CC_EARLY_HI_WR_IN),
  .CC_EARLY_STATUS_OUT(CC_EARLY_STATUS_OUT), .CC_LATE_STATUS_OUT(CC_LATE_STATUS_OUT),
  .OUTPUT_ONE_OUT(OUTPUT_ONE_OUT), .OUTPUT_TWO_OUT(OUTPUT_TWO_OUT),
  .OUTPUT_THREE_OUT(OUTPUT_THREE_OUT), .OUTPUT_FOUR_OUT(OUTPUT_FOUR_OUT),
  .VREF_EN_OUT(VREF_EN_OUT));
`default_nettype wire

//--- dv/video_sink.sv
/*
  Downstream display model: samples the four converter codes each clock.
  Assumes one new code per converter per clock edge.
*/
`default_nettype none
module video_sink (
  // clock
  input  wire logic       clk_in,
  // converter codes
  input  wire logic [9:0] one_in,
  input  wire logic [9:0] two_in,
  input  wire logic [9:0] three_in,
  input  wire logic [9:0] four_in,
  // captured samples
  output logic      [9:0] one_out,
  output logic      [9:0] two_out,
  output logic      [9:0] three_out,
  output logic      [9:0] four_out
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk_in) begin
    one_out <= one_in;
    two_out <= two_in;
    three_out <= three_in;
    four_out <= four_in;
  end
endmodule
`default_nettype wire

//--- dv/tb.sv
/*
  Self-checking bench for the encoder back end.
  Assumes inputs change at the falling edge; sink model captures outputs.
*/
`default_nettype none
module tb;
  import venc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, scart, lim, pd, fst, act, sync;
  logic [7:0] fmt, ccd, y;
  logic signed [7:0] cb;
  logic [1:0] cc_en;
  logic [3:0] dac_en, wr;
  logic [9:0] line, pix, o1, o2, o3, o4, s1, s2, s3, s4;
  logic st_e, st_l, vref;
  int bad_count, checked;
  venc_backend dut_u (.CLK_IN(clk), .RST_N_IN(rst_n), .OUT_FORMAT_IN(fmt), .SCART_IN(scart),
    .LIMIT_EN_IN(lim), .PEDESTAL_EN_IN(1'b0), .PHASE_RESET_EN_IN(1'b1), .CC_ENABLE_IN(cc_en),
    .DAC_EN_IN(dac_en), .POWER_DOWN_IN(pd), .SC_INCR_IN(32'h21f07c1f),
    .CC_EARLY_LO_WR_IN(wr[0]), .CC_EARLY_HI_WR_IN(wr[1]), .CC_LATE_LO_WR_IN(wr[2]),
    .CC_LATE_HI_WR_IN(wr[3]), .CC_DATA_IN(ccd), .LINE_IN(line), .PIXEL_IN(pix),
    .FIELD_START_IN(fst), .ACTIVE_IN(act), .SYNC_IN(sync), .BURST_IN(1'b0), .Y_IN(y),
    .CB_IN(cb), .CR_IN(8'sh00), .CC_EARLY_STATUS_OUT(st_e), .CC_LATE_STATUS_OUT(st_l),
    .OUTPUT_ONE_OUT(o1), .OUTPUT_TWO_OUT(o2), .OUTPUT_THREE_OUT(o3), .OUTPUT_FOUR_OUT(o4),
    .VREF_EN_OUT(vref));
  video_sink sink_u (.clk_in(clk), .one_in(o1), .two_in(o2), .three_in(o3), .four_in(o4),
    .one_out(s1), .two_out(s2), .three_out(s3), .four_out(s4));
  // ----
  // helpers
  // ----
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk_sample(input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic put(input int which, input logic [7:0] d);
    ccd = d;
    wr = 4'h1 << which;
    cyc(1);
    wr = 4'h0;
    cyc(1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_power;
    pd = 1'b1;
    cyc(4);
    chk_sample(s1 | s2 | s3 | s4, 10'h000);
    chk_flag(vref, 1'b0);
    pd = 1'b0;
    cyc(4);
    chk_flag(vref, 1'b1);
  endtask
  task automatic t_dac;
    dac_en = 4'h6;
    cyc(4);
    chk_sample(s1, 10'h000);
    chk_sample(s4, 10'h000);
    dac_en = 4'hf;
  endtask
  task automatic t_route;
    logic [9:0] comp;
    fmt = 8'h00;
    cyc(8);
    comp = s3;
    chk_sample(s4, comp);
    fmt = 8'h08;
    cyc(8);
    chk_sample(s4, comp);
    fmt = 8'h10;
    cyc(8);
    chk_sample(s3, comp);
    sync = 1'b1;
    cyc(8);
    chk_sample(s1, s4);
    sync = 1'b0;
    scart = 1'b1;
    cyc(8);
    chk_sample(s1, comp);
    fmt = 8'h18;
    cyc(8);
    chk_sample(s1, comp);
    sync = 1'b1;
    cyc(8);
    chk_flag(s3 < s2, 1'b1);
    sync = 1'b0;
    scart = 1'b0;
    fmt = 8'h00;
  endtask
  task automatic t_limit;
    lim = 1'b1;
    y = 8'h00;
    sync = 1'b1;
    cyc(8);
    chk_flag(s3 >= LIMIT_MIN, 1'b1);
    lim = 1'b0;
    cyc(8);
    chk_flag(s3 < LIMIT_MIN, 1'b1);
    sync = 1'b0;
    y = 8'h80;
  endtask
  task automatic t_caption(input logic [1:0] en, input logic [9:0] ln, input int base,
                           input logic [15:0] word, input logic load);
    int          n;
    logic [9:0]  hi;
    logic [9:0]  lo;
    logic [27:0] pat;
    pat = {word, 3'b100, 9'h155};
    hi = 10'h000;
    lo = 10'h000;
    cc_en = en;
    if (load) begin
      put(base + int'(en[1]), en[1] ? word[15:8] : word[7:0]);
      put(base + int'(en[0]), en[1] ? word[7:0] : word[15:8]);
    end
    chk_flag(en[0] ? st_e : st_l, !load);
    chk_flag(en[0] ? st_l : st_e, 1'b1);
    line = ln;
    for (int p = 0; p < 300; p++) begin
      pix = 10'(p);
      fst = (p == 0);
      sync = (p < 10);
      cb = 8'sh30;
      if (p == 29) hi = s1;
      if (p == 34) lo = s1;
      if (p >= 34 && p < 165 && (p - 29) % 5 == 0) begin
        chk_flag({s1, 1'b0} > 11'(hi) + 11'(lo), pat[(p - 29) / 5]);
      end
      if (p == 100) chk_flag(en[0] ? st_e : st_l, !load);
      cyc(1);
    end
    line = 10'h064;
    n = 0;
    while ((en[0] ? st_e : st_l) !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    chk_flag(en[0] ? st_e : st_l, 1'b1);
    if ((en[0] ? st_e : st_l) !== 1'b1) report_and_stop;
    cb = 8'sh00;
  endtask
  task automatic t_cc_off;
    cc_en = 2'h0;
    put(0, 8'h11);
    put(1, 8'h22);
    chk_flag(st_e, 1'b1);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {rst_n, scart, lim, pd, fst, sync, wr, cc_en} = '0;
    {fmt, ccd, cb, bad_count, checked} = '0;
    {act, dac_en, y, line, pix} = {1'b1, 4'hf, 8'h80, 10'h064, 10'h12c};
    cyc(6);
    chk_flag(st_e, 1'b1);
    chk_flag(vref, 1'b0);
    cyc(2);
    rst_n = 1'b1;
    cyc(4);
    t_power();
    t_dac();
    t_route();
    t_limit();
    t_caption(2'h1, CC_EARLY_NTSC, 0, 16'h2a55, 1'b1);
    t_caption(2'h1, CC_EARLY_NTSC, 0, 16'h2a55, 1'b0);
    fmt = 8'h40;
    t_caption(2'h2, CC_LATE_PAL, 2, 16'hc3a1, 1'b1);
    fmt = 8'h00;
    t_cc_off();
    report_and_stop();
  end
endmodule
`default_nettype wire
